// file: hw/iavs_capture.sv
// top of the general-input and processor id status capture
// assumes the serial register engine issues one-cycle read strobes
// and that all pins are already synchronous to the core clock
`timescale 1ns/1ps
module iavs_capture
  import iavs_pkg::*;
#(
  parameter int unsigned STABLE_CYC = iavs_pkg::IAVS_VID_STABLE_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_gpio_pins,
  input wire logic [7:0] i_vid_pins,
  input wire iavs_pkg::iavs_mode_t i_vid_mode,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_rd_hit,
  output logic [7:0] o_general_input_levels,
  output logic [7:0] o_processor_one_voltage_id
);
  import iavs_pkg::*;

  // carrier from the filter
  iavs_vid_if vid_bus ();

  // mapped id byte for the present mode
  logic [7:0] vid_mapped;

  // live view of the general inputs, inverted
  logic [7:0] gpi_r;
  logic [7:0] gpi_nxt;

  // captured id status byte
  logic [7:0] vid_r;
  logic [7:0] vid_nxt;

  // read port outputs
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_hit_r;
  logic rd_hit_nxt;

  // steadiness filter on the id pins
  iavs_vid_filter #(
    .STABLE_CYC(STABLE_CYC)
  ) u_filter (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_vid_pins(i_vid_pins),
    .vid(vid_bus.filt)
  );

  // mode mapping of the steady word
  iavs_vid_mapper u_mapper (
    .i_pins(vid_bus.vid_word),
    .i_mode(i_vid_mode),
    .o_byte(vid_mapped)
  );

  // general inputs read one while the pin is low
  always_comb begin
    gpi_nxt = ~i_gpio_pins;
  end

  // no latching: each cycle overwrites the last view
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      gpi_r <= IAVS_RST_GPI;
    end else begin
      gpi_r <= gpi_nxt;
    end
  end

  // take the mapped word only while pins are steady
  always_comb begin
    if (vid_bus.steady) begin
      vid_nxt = vid_mapped;
    end else begin
      vid_nxt = vid_r;
    end
  end

  // id status register, held between steady windows
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      vid_r <= IAVS_RST_VID;
    end else begin
      vid_r <= vid_nxt;
    end
  end

  // read decode, unmapped offsets answer zero
  always_comb begin
    rd_data_nxt = IAVS_UNMAPPED;
    rd_hit_nxt = 1'b0;
    case (i_rd_addr)
      IAVS_OFF_GPI: begin
        rd_data_nxt = gpi_r;
        rd_hit_nxt = 1'b1;
      end
      IAVS_OFF_VID: begin
        rd_data_nxt = vid_r;
        rd_hit_nxt = 1'b1;
      end
      default: begin
        rd_data_nxt = IAVS_UNMAPPED;
        rd_hit_nxt = 1'b0;
      end
    endcase
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_data_r <= IAVS_UNMAPPED;
      rd_hit_r <= 1'b0;
    end else if (i_rd_en) begin
      rd_data_r <= rd_data_nxt;
      rd_hit_r <= rd_hit_nxt;
    end
  end

  // answer strobe, one cycle wide
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= i_rd_en;
    end
  end

  // outputs straight from flip-flops
  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;
  assign o_rd_hit = rd_hit_r;
  assign o_general_input_levels = gpi_r;
  assign o_processor_one_voltage_id = vid_r;

  // checks: the helper logic below feeds only the assertions, so the
  // datapath never reads it and synthesis trims it away

  // helper: cycles since the id pins last changed, saturating
  localparam int unsigned SW = $clog2(STABLE_CYC + 2);
  logic [SW-1:0] since_chg_r;
  logic [7:0] vid_prev_r;

  // helper history of the id pins for the checks only
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      vid_prev_r <= 8'h00;
      since_chg_r <= '0;
    end else begin
      vid_prev_r <= i_vid_pins;
      if (i_vid_pins != vid_prev_r) begin
        since_chg_r <= '0;
      end else if (since_chg_r != SW'(STABLE_CYC + 1)) begin
        since_chg_r <= since_chg_r + SW'(1);
      end
    end
  end

  // every check samples on the core clock and idles during reset
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // a change on the id pins as the filter will see it
  sequence s_pin_step;
    $changed(i_vid_pins);
  endsequence

  // id byte left alone for a whole quiet stretch
  sequence s_no_update;
    $stable(vid_r)[*8];
  endsequence

  // read strobe aimed at the general input offset
  sequence s_rd_gpi;
    i_rd_en && (i_rd_addr == IAVS_OFF_GPI);
  endsequence

  // read strobe aimed at the id status offset
  sequence s_rd_vid;
    i_rd_en && (i_rd_addr == IAVS_OFF_VID);
  endsequence

  // read strobe aimed at neither mapped offset
  sequence s_rd_other;
    i_rd_en && (i_rd_addr != IAVS_OFF_GPI) && (i_rd_addr != IAVS_OFF_VID);
  endsequence

  // register is zero right after reset
  property p_gpi_reset;
    @(posedge i_core_clk) $past(i_sys_rst) |-> (o_general_input_levels == IAVS_RST_GPI);
  endproperty

  // general input byte starts from zero
  chk_gpi_reset_zero: assert property (p_gpi_reset)
    else $error("general input status not zero after reset");

  // a read of the general input offset returns the live byte
  chk_gpi_read_offset: assert property (
    s_rd_gpi |=> o_rd_hit && (o_rd_data == $past(gpi_r)))
    else $error("general input status not returned at its offset");

  // each bit shows the inverse of its pin one cycle on
  chk_gpi_low_active: assert property (
    !$past(i_sys_rst) |-> (o_general_input_levels == ~$past(i_gpio_pins)))
    else $error("general input bit does not show inverted pin");

  // a released pin 0 clears bit 0 one cycle on
  chk_gpi_no_latch: assert property (
    $rose(i_gpio_pins[0]) |=> !o_general_input_levels[0])
    else $error("released general input still reads active");

  // six-bit layout: low six pins, top two bits clear
  chk_vid_six_bit: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_SIX_BIT)
      |=> (o_processor_one_voltage_id == {2'h0, $past(vid_bus.vid_word[5:0])}))
    else $error("six bit mode layout wrong");

  // extended layout: low seven pins, top bit clear
  chk_vid_ext_seven: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_EXT_SEVEN)
      |=> (o_processor_one_voltage_id == {1'b0, $past(vid_bus.vid_word[6:0])}))
    else $error("extended seven bit mode layout wrong");

  // first eleven-series layout: low seven pins
  chk_vid_eleven_first: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_ELEVEN_FIRST)
      |=> (o_processor_one_voltage_id[6:0] == $past(i_vid_pins[6:0], 2)))
    else $error("first eleven mode layout wrong");

  // first eleven-series layout keeps its top bit clear
  chk_vid_first_top: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_ELEVEN_FIRST) |=> !o_processor_one_voltage_id[7])
    else $error("first eleven mode top bit set");

  // second eleven-series layout: top seven pins
  chk_vid_eleven_second: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_ELEVEN_SECOND)
      |=> (o_processor_one_voltage_id[7:1] == $past(i_vid_pins[7:1], 2)))
    else $error("second eleven mode layout wrong");

  // second eleven-series layout keeps its bottom bit clear
  chk_vid_second_low: assert property (
    vid_bus.steady && (i_vid_mode == IAVS_MODE_ELEVEN_SECOND) |=> !o_processor_one_voltage_id[0])
    else $error("second eleven mode bottom bit set");

  // reserved bits of the layout in force read zero on every update
  chk_vid_reserved_zero: assert property (
    $changed(o_processor_one_voltage_id) |->
      ((($past(i_vid_mode) == IAVS_MODE_SIX_BIT) && (o_processor_one_voltage_id[7:6] == 2'h0))
      || (($past(i_vid_mode) == IAVS_MODE_ELEVEN_SECOND) && !o_processor_one_voltage_id[0])
      || (($past(i_vid_mode) != IAVS_MODE_SIX_BIT)
        && ($past(i_vid_mode) != IAVS_MODE_ELEVEN_SECOND)
        && !o_processor_one_voltage_id[7])))
    else $error("reserved id bit reads one");

  // the id byte is zero right after reset
  chk_vid_reset_zero: assert property (
    $past(i_sys_rst) |-> (o_processor_one_voltage_id == IAVS_RST_VID))
    else $error("id status not zero after reset");

  // a fresh word lands only after the full quiet count; a remap on a mode
  // change reuses the word already held steady and is exempt
  chk_vid_settle_time: assert property (
    $changed(o_processor_one_voltage_id) && ($past(i_vid_mode) == $past(i_vid_mode, 2))
      |-> ($past(since_chg_r) >= SW'(STABLE_CYC)))
    else $error("id byte updated before pins were steady long enough");

  // the change edge itself may still take the old steady word, so the quiet
  // stretch starts one edge later; needs a steadiness count of 8 or more
  chk_vid_quiet_after: assert property (
    s_pin_step |-> ##2 s_no_update)
    else $error("id byte moved right after a pin change");

  // filter flag agrees with an independent count of quiet cycles
  chk_vid_steady_flag: assert property (
    (since_chg_r >= SW'(STABLE_CYC)) == vid_bus.steady)
    else $error("steady flag disagrees with quiet cycle count");

  // an unsteady filter freezes the id byte
  chk_vid_hold_value: assert property (
    !vid_bus.steady |=> $stable(o_processor_one_voltage_id))
    else $error("id byte changed while pins were unsteady");

  // a read of the id offset returns the held id byte
  chk_vid_read_offset: assert property (
    s_rd_vid |=> o_rd_hit && (o_rd_data == $past(vid_r)))
    else $error("id status not returned at its offset");

  // unmapped offsets answer zero without a hit
  chk_rd_unmapped_zero: assert property (
    s_rd_other |=> !o_rd_hit && (o_rd_data == IAVS_UNMAPPED))
    else $error("unmapped offset returned data");

  // read answer holds between strobes
  chk_rd_data_hold: assert property (
    !i_rd_en |=> $stable(o_rd_data) && $stable(o_rd_hit))
    else $error("read answer moved without a strobe");

  // every read strobe is answered one cycle on
  chk_rd_strobe_once: assert property (
    i_rd_en |=> o_rd_valid)
    else $error("read answer strobe missing");

  // no answer strobe appears without a request
  chk_rd_valid_idle: assert property (
    !i_rd_en |=> !o_rd_valid)
    else $error("read answer strobe without a request");
endmodule

// file: hw/iavs_pkg.sv
// constants, types and the mode mapping for the input and id status capture
// assumes one 50 MHz core clock and a synchronous active-high reset
// Behaviour
// - general-input status byte at 6Bh, resets zero
// - status bit reads one while its pin low
// - status bits follow pins, nothing latched
// - id byte layout follows mode from BDh
// - six-bit mode: pins 5:0, bits 7:6 zero
// - extended mode: pins 6:0, bit 7 zero
// - first eleven mode: pins 6:0, bit 7 zero
// - second eleven mode: pins 7:1, bit 0 zero
// - reserved id bits read zero for the mode in force at the last id load
// - id loads only after 600 ns steady
package iavs_pkg;

  // data width of every status byte
  localparam int unsigned IAVS_DW = 8;

  // register offsets on the register read port
  localparam logic [7:0] IAVS_OFF_GPI = 8'h6b;
  localparam logic [7:0] IAVS_OFF_VID = 8'h6c;
  // offset of the outside control register holding the mode field
  localparam logic [7:0] IAVS_OFF_MODE_CTRL = 8'hbd;

  // reset values and the answer to an unmapped offset
  localparam logic [7:0] IAVS_RST_GPI = 8'h00;
  localparam logic [7:0] IAVS_RST_VID = 8'h00;
  localparam logic [7:0] IAVS_UNMAPPED = 8'h00;

  // timing: clock period and least steady time of the id pins
  localparam int unsigned IAVS_CLK_PERIOD_NS = 20;
  localparam int unsigned IAVS_VID_STABLE_NS = 600;
  // least time rounds up to whole cycles, never below one
  localparam int unsigned IAVS_VID_STABLE_CYC_RAW =
    (IAVS_VID_STABLE_NS + IAVS_CLK_PERIOD_NS - 1) / IAVS_CLK_PERIOD_NS;
  localparam int unsigned IAVS_VID_STABLE_CYC =
    (IAVS_VID_STABLE_CYC_RAW < 1) ? 1 : IAVS_VID_STABLE_CYC_RAW;

  // regulator mode field encodings
  typedef logic [1:0] iavs_mode_t;
  localparam iavs_mode_t IAVS_MODE_SIX_BIT = 2'h0;
  localparam iavs_mode_t IAVS_MODE_EXT_SEVEN = 2'h1;
  localparam iavs_mode_t IAVS_MODE_ELEVEN_FIRST = 2'h2;
  localparam iavs_mode_t IAVS_MODE_ELEVEN_SECOND = 2'h3;

  // places steady id pins into the status byte for one mode
  function automatic logic [7:0] iavs_map_vid(input logic [7:0] pins, input iavs_mode_t mode);
    logic [7:0] res;
    res = 8'h00;
    case (mode)
      IAVS_MODE_SIX_BIT: res = {2'h0, pins[5:0]};
      IAVS_MODE_EXT_SEVEN: res = {1'b0, pins[6:0]};
      IAVS_MODE_ELEVEN_FIRST: res = {1'b0, pins[6:0]};
      IAVS_MODE_ELEVEN_SECOND: res = {pins[7:1], 1'b0};
      default: res = 8'h00;
    endcase
    return res;
  endfunction

endpackage

// file: hw/iavs_vid_filter.sv
// steadiness filter for the processor id pins
// assumes the pins are synchronous to the core clock
`timescale 1ns/1ps
module iavs_vid_filter
  import iavs_pkg::*;
#(
  parameter int unsigned STABLE_CYC = iavs_pkg::IAVS_VID_STABLE_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_vid_pins,
  iavs_vid_if.filt vid
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] CNT_TOP = CW'(STABLE_CYC);

  logic [7:0] sample_r; // previous pin sample
  logic [CW-1:0] quiet_r; // cycles pins have matched the sample

  // sample the pins every cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sample_r <= 8'h00;
    end else begin
      sample_r <= i_vid_pins;
    end
  end

  // restart on any change, count up and stick at the top
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      quiet_r <= '0;
    end else if (i_vid_pins != sample_r) begin
      quiet_r <= '0;
    end else if (quiet_r != CNT_TOP) begin
      quiet_r <= quiet_r + CW'(1);
    end
  end

  assign vid.vid_word = sample_r;
  assign vid.steady = (quiet_r == CNT_TOP);
endmodule

// file: hw/iavs_vid_if.sv
// carrier between the id steadiness filter and the capture top
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface iavs_vid_if;
  logic [7:0] vid_word; // id pins as last sampled
  logic steady; // pins held long enough to be taken
  modport filt (output vid_word, output steady);
  modport user (input vid_word, input steady);
endinterface

// file: hw/iavs_vid_mapper.sv
// mode-dependent placement of the steady id pins
// assumes the mode field comes from the outside control register
`timescale 1ns/1ps
module iavs_vid_mapper
  import iavs_pkg::*;
(
  input wire logic [7:0] i_pins,
  input wire iavs_pkg::iavs_mode_t i_mode,
  output logic [7:0] o_byte
);
  // layout chosen purely by the mode, reserved bits forced low
  always_comb begin
    o_byte = iavs_map_vid(i_pins, i_mode);
  end
endmodule

// file: test/iavs_pin_model.sv
// board-side model of the general input pins and the processor id pins
// assumes the bench sets the requested levels just after a core clock edge
`timescale 1ns/1ps
module iavs_pin_model (
  input wire logic [7:0] i_gpio_pull_low, // pins pulled low by the board
  input wire logic [7:0] i_vid_level, // levels the regulator presents
  output logic [7:0] o_gpio_pins, // general input pin levels
  output logic [7:0] o_vid_pins // processor one id pin levels
);
  // open-drain inputs with pull-ups: a released pin reads high
  assign o_gpio_pins = ~i_gpio_pull_low;
  // id pins are driven push-pull by the regulator side
  assign o_vid_pins = i_vid_level;
endmodule

// file: test/input_and_vid_status_capture_tb.sv
// self-checking bench for the input and id status capture
// assumes a short steadiness count of 8 cycles, the least the quiet check allows
`timescale 1ns/1ps
module input_and_vid_status_capture_tb;
  import iavs_pkg::*;
  localparam int STB = 8; // shortened steadiness count
  logic i_core_clk = 1'b0; // core clock
  logic i_sys_rst = 1'b1; // synchronous reset
  logic rd_en = 1'b0; // read strobe
  logic [7:0] rd_addr = 8'h00; // read offset
  logic [7:0] pull_low = 8'h00; // gpio pins pulled low
  logic [7:0] vid_lvl = 8'h00; // id pin levels
  iavs_pkg::iavs_mode_t vid_mode = 2'h0; // regulator mode field
  wire logic [7:0] gpio_pins; // pin levels to the design
  wire logic [7:0] vid_pins; // id pins to the design
  logic [7:0] rd_data; // read answer
  logic rd_valid; // answer strobe
  logic rd_hit; // mapped offset flag
  logic [7:0] gpi_byte; // live input status byte
  logic [7:0] vid_byte; // captured id status byte
  int failures = 0; // mismatch count
  int n_compared = 0; // comparison count

  // clock: 50 MHz
  always #10 i_core_clk = ~i_core_clk;

  // far side of the pins
  iavs_pin_model pins (.i_gpio_pull_low(pull_low), .i_vid_level(vid_lvl),
    .o_gpio_pins(gpio_pins), .o_vid_pins(vid_pins));

  // block under test
  iavs_capture #(.STABLE_CYC(STB)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_gpio_pins(gpio_pins), .i_vid_pins(vid_pins), .i_vid_mode(vid_mode),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_rd_hit(rd_hit), .o_general_input_levels(gpi_byte),
    .o_processor_one_voltage_id(vid_byte));

  // verdict and end of run
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one comparison, counted
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register read, answer judged just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit_exp);
    @(posedge i_core_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge i_core_clk);
    rd_en <= 1'b0;
    #1;
    check({7'h00, rd_valid}, 8'h01);
    check(rd_data, exp);
    check({7'h00, rd_hit}, {7'h00, hit_exp});
  endtask

  // expected id byte for one mode, worked out bit by bit
  function automatic logic [7:0] exp_vid(input logic [7:0] p, input logic [1:0] m);
    case (m)
      2'h0: return {2'h0, p[5:0]};
      2'h1, 2'h2: return {1'b0, p[6:0]};
      default: return {p[7:1], 1'b0};
    endcase
  endfunction

  // reset values and an unmapped offset
  task automatic test_reset();
    rd(IAVS_OFF_GPI, 8'h00, 1'b1);
    rd(IAVS_OFF_VID, 8'h00, 1'b1);
    rd(8'h6a, 8'h00, 1'b0);
  endtask

  // each input pin low in turn, then a short low pulse that ends
  task automatic test_gpio();
    for (int i = 0; i < 8; i++) begin
      @(posedge i_core_clk);
      pull_low <= 8'h01 << i;
      rd(IAVS_OFF_GPI, 8'h01 << i, 1'b1);
    end
    @(posedge i_core_clk);
    pull_low <= 8'h81;
    @(posedge i_core_clk);
    pull_low <= 8'h00;
    #1;
    check(gpi_byte, 8'h81);
    rd(IAVS_OFF_GPI, 8'h00, 1'b1);
  endtask

  // every mode with all pins high and with a mixed pattern
  task automatic test_modes();
    logic [7:0] pat[2];
    pat[0] = 8'hff;
    pat[1] = 8'h5a;
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge i_core_clk);
        vid_mode <= 2'(m);
        vid_lvl <= pat[j];
        repeat (STB + 3) @(posedge i_core_clk);
        rd(IAVS_OFF_VID, exp_vid(pat[j], 2'(m)), 1'b1);
        check(vid_byte, exp_vid(pat[j], 2'(m)));
      end
    end
  endtask

  // bouncing pins are refused, a steady value lands on the exact edge
  task automatic test_steady();
    @(posedge i_core_clk);
    vid_mode <= 2'h0;
    vid_lvl <= 8'h15;
    repeat (STB + 3) @(posedge i_core_clk);
    #1;
    check(vid_byte, 8'h15);
    for (int i = 0; i < 6; i++) begin
      @(posedge i_core_clk);
      vid_lvl <= (i % 2) ? 8'h2a : 8'h3f;
      #1;
      check(vid_byte, 8'h15);
    end
    @(posedge i_core_clk);
    vid_lvl <= 8'h3c;
    repeat (STB + 1) @(posedge i_core_clk);
    #1;
    check(vid_byte, 8'h15);
    @(posedge i_core_clk);
    #1;
    check(vid_byte, 8'h3c);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    test_reset();
    test_gpio();
    test_modes();
    test_steady();
    finish_test();
  end

  // watchdog against a hang
  initial begin
    #(20 * 4000);
    failures++;
    finish_test();
  end
endmodule
